// ### sbrs_pkg.sv
package sbrs_pkg;

    // Clock and timing
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned SOFT_RST_MS = 10;
    localparam int unsigned SOFT_RST_CYC = CYC_PER_MS * SOFT_RST_MS;
    localparam int unsigned TGT_TIMEOUT_MS = 1000;
    localparam int unsigned TGT_TIMEOUT_CYC = CYC_PER_MS * TGT_TIMEOUT_MS;

    // Flash map, byte addresses
    localparam logic [31:0] MAIN_PAGE_START = 32'h0000_0000;
    localparam logic [31:0] MAIN_PAGE_END = 32'h0036_8E43;
    localparam logic [31:0] MAIN_PROG_START = 32'h0036_8E44;
    localparam logic [31:0] MAIN_PROG_END = 32'h0037_A13B;
    localparam logic [31:0] DB_IMAGE_START = 32'h0040_0000;
    localparam logic [31:0] MAIN_PROG_LEN = MAIN_PROG_END - MAIN_PROG_START + 32'h0000_0001;

    // Split of the main configuration page into self and IO images; detector image length
    localparam logic [31:0] SELF_IMAGE_START = MAIN_PAGE_START;
    localparam logic [31:0] SELF_IMAGE_LEN = 32'h0012_4000;
    localparam logic [31:0] IO0_IMAGE_START = 32'h0012_4000;
    localparam logic [31:0] IO1_IMAGE_START = 32'h0024_6000;
    localparam logic [31:0] IO_IMAGE_LEN = 32'h0012_2000;
    localparam logic [31:0] DB_IMAGE_LEN = 32'h0010_0000;

    // Serial flash
    localparam logic [7:0] FLASH_READ_CMD = 8'h03;
    localparam logic [5:0] FLASH_HDR_LAST_BIT = 6'h1F;
    localparam logic [5:0] FLASH_BYTE_LAST_BIT = 6'h07;

    // System size
    localparam int unsigned IO_COUNT = 2;
    localparam int unsigned DB_COUNT = 8;

    typedef enum logic [2:0] {
        TGT_SELF,
        TGT_IO0,
        TGT_IO1,
        TGT_PROG,
        TGT_DB
    } sbrs_tgt_t;

endpackage

// ### sbrs_flash_if.sv
`timescale 1ns/1ps
interface sbrs_flash_if;
    logic req;
    logic abort;
    logic [31:0] addr;
    logic [31:0] len;
    logic [7:0] data;
    logic valid;
    logic done;
    logic busy;

    modport seq (
        output req,
        output abort,
        output addr,
        output len,
        input data,
        input valid,
        input done,
        input busy
    );

    modport rdr (
        input req,
        input abort,
        input addr,
        input len,
        output data,
        output valid,
        output done,
        output busy
    );
endinterface

// ### sbrs_flash_reader.sv
`timescale 1ns/1ps
module sbrs_flash_reader
    import sbrs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    sbrs_flash_if.rdr fl,
    output logic flash_sck,
    output logic flash_cs_n,
    output logic flash_mosi,
    input wire logic flash_miso
);

    typedef enum logic [1:0] {
        R_IDLE,
        R_HDR,
        R_DATA
    } sbrs_rd_state_t;

    sbrs_rd_state_t state, next_state;
    logic [31:0] shreg, next_shreg;
    logic [5:0] bitcnt, next_bitcnt;
    logic [31:0] remain, next_remain;
    logic [7:0] rx, next_rx;
    logic [7:0] data, next_data;
    logic valid, next_valid;
    logic done, next_done;
    logic sck, next_sck;
    logic cs_n, next_cs_n;
    logic mosi, next_mosi;

    assign fl.data = data;
    assign fl.valid = valid;
    assign fl.done = done;
    assign fl.busy = (state != R_IDLE);
    assign flash_sck = sck;
    assign flash_cs_n = cs_n;
    assign flash_mosi = mosi;

    // SCK runs at half the system clock; miso sampled as SCK rises
    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_remain = remain;
        next_rx = rx;
        next_data = data;
        next_valid = 1'b0;
        next_done = 1'b0;
        next_sck = sck;
        next_cs_n = cs_n;
        next_mosi = mosi;
        if (fl.abort) begin
            next_state = R_IDLE;
            next_sck = 1'b0;
            next_cs_n = 1'b1;
            next_mosi = 1'b0;
        end else begin
            case (state)
                R_IDLE: begin
                    if (fl.req) begin
                        if (fl.len == 32'h0000_0000) begin
                            next_done = 1'b1;
                        end else begin
                            // Only 24 address bits go out; the map stays below 16 MB
                            next_shreg = {FLASH_READ_CMD, fl.addr[23:0]};
                            next_bitcnt = FLASH_HDR_LAST_BIT;
                            next_remain = fl.len;
                            next_cs_n = 1'b0;
                            next_mosi = FLASH_READ_CMD[7];
                            next_state = R_HDR;
                        end
                    end
                end
                R_HDR: begin
                    if (!sck) begin
                        next_sck = 1'b1;
                    end else begin
                        next_sck = 1'b0;
                        if (bitcnt == 6'h00) begin
                            next_bitcnt = FLASH_BYTE_LAST_BIT;
                            next_state = R_DATA;
                        end else begin
                            next_shreg = {shreg[30:0], 1'b0};
                            next_mosi = shreg[30];
                            next_bitcnt = bitcnt - 6'h01;
                        end
                    end
                end
                R_DATA: begin
                    if (!sck) begin
                        next_sck = 1'b1;
                        next_rx = {rx[6:0], flash_miso};
                    end else begin
                        next_sck = 1'b0;
                        if (bitcnt == 6'h00) begin
                            next_data = rx;
                            next_valid = 1'b1;
                            next_remain = remain - 32'h0000_0001;
                            next_bitcnt = FLASH_BYTE_LAST_BIT;
                            if (remain == 32'h0000_0001) begin
                                next_done = 1'b1;
                                next_cs_n = 1'b1;
                                next_mosi = 1'b0;
                                next_state = R_IDLE;
                            end
                        end else begin
                            next_bitcnt = bitcnt - 6'h01;
                        end
                    end
                end
                default: begin
                    next_state = R_IDLE;
                    next_cs_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state <= R_IDLE;
            shreg <= 32'h0000_0000;
            bitcnt <= 6'h00;
            remain <= 32'h0000_0000;
            rx <= 8'h00;
            data <= 8'h00;
            valid <= 1'b0;
            done <= 1'b0;
            sck <= 1'b0;
            cs_n <= 1'b1;
            mosi <= 1'b0;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            remain <= next_remain;
            rx <= next_rx;
            data <= next_data;
            valid <= next_valid;
            done <= next_done;
            sck <= next_sck;
            cs_n <= next_cs_n;
            mosi <= next_mosi;
        end
    end

endmodule

// ### sbrs_boot_sequencer.sv
`timescale 1ns/1ps
// Behaviour
// - Main FPGA loads itself first, then the IO FPGAs one after another.
// - Two separate IO images in flash, each delivered to its own IO FPGA.
// - Main program copied and started only after both IO FPGAs configured.
// - Program order: Ethernet init, node init, soft reset, detector boards.
// - Main FPGA masters the flash and programs all detector boards together.
// - Detector images read from byte address 0x00400000; addresses are bytes.
// - Config page at 0x0..0x368E43, main program at 0x368E44..0x37A13B.
// - Each IO FPGA runs, initialises, resets, then idles awaiting SPI.
// - Each detector board runs, resets, waits for SPI; boot then ends.
// - Hard reset button stops every FPGA and overrides all other resets.
// - Firmware reset keeps FPGAs configured but unlocks the PLL.
// - System clock is passed on only while the PLL reports lock.
// - Soft reset with PLL locked hits only comms blocks, about 10 ms.
module sbrs_boot_sequencer
    import sbrs_pkg::*;
#(
    parameter int unsigned SOFT_RST_CYC_P = sbrs_pkg::SOFT_RST_CYC,
    parameter int unsigned TGT_TIMEOUT_CYC_P = sbrs_pkg::TGT_TIMEOUT_CYC
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic hard_reset_btn,
    input wire logic fw_reset_req,
    input wire logic pll_locked,
    output logic flash_sck,
    output logic flash_cs_n,
    output logic flash_mosi,
    input wire logic flash_miso,
    input wire logic self_cfg_done,
    input wire logic [sbrs_pkg::IO_COUNT-1:0] io_cfg_done,
    input wire logic [sbrs_pkg::IO_COUNT-1:0] io_idle,
    input wire logic [sbrs_pkg::DB_COUNT-1:0] db_cfg_done,
    input wire logic [sbrs_pkg::DB_COUNT-1:0] db_idle,
    input wire logic eth_init_done,
    input wire logic node_init_done,
    output logic [7:0] cfg_data,
    output logic self_cfg_wr,
    output logic [sbrs_pkg::IO_COUNT-1:0] io_cfg_wr,
    output logic prog_wr,
    output logic db_cfg_wr,
    output logic fpga_stop,
    output logic prog_run,
    output logic eth_init_start,
    output logic node_init_start,
    output logic soft_rst,
    output logic pll_rst,
    output logic sys_clk_en,
    output logic boot_busy,
    output logic boot_done,
    output logic boot_error
);
    import sbrs_pkg::*;

    typedef enum logic [3:0] {
        ST_STOP,
        ST_LOAD,
        ST_WAIT,
        ST_ETH,
        ST_NODE,
        ST_SOFT,
        ST_SETTLE,
        ST_DONE,
        ST_ERROR
    } sbrs_state_t;

    localparam logic [31:0] TIMEOUT_LAST = 32'(TGT_TIMEOUT_CYC_P - 1);
    localparam logic [31:0] SOFT_LAST = 32'(SOFT_RST_CYC_P - 1);

    function automatic logic [31:0] tgt_addr(input sbrs_tgt_t t);
        case (t)
            TGT_SELF: tgt_addr = SELF_IMAGE_START;
            TGT_IO0: tgt_addr = IO0_IMAGE_START;
            TGT_IO1: tgt_addr = IO1_IMAGE_START;
            TGT_PROG: tgt_addr = MAIN_PROG_START;
            TGT_DB: tgt_addr = DB_IMAGE_START;
            default: tgt_addr = SELF_IMAGE_START;
        endcase
    endfunction

    function automatic logic [31:0] tgt_len(input sbrs_tgt_t t);
        case (t)
            TGT_SELF: tgt_len = SELF_IMAGE_LEN;
            TGT_IO0: tgt_len = IO_IMAGE_LEN;
            TGT_IO1: tgt_len = IO_IMAGE_LEN;
            TGT_PROG: tgt_len = MAIN_PROG_LEN;
            TGT_DB: tgt_len = DB_IMAGE_LEN;
            default: tgt_len = 32'h0000_0000;
        endcase
    endfunction

    sbrs_flash_if fl ();

    sbrs_flash_reader u_reader (
        .clk_sys(clk_sys),
        .reset(reset),
        .fl(fl),
        .flash_sck(flash_sck),
        .flash_cs_n(flash_cs_n),
        .flash_mosi(flash_mosi),
        .flash_miso(flash_miso)
    );

    sbrs_state_t state, next_state;
    sbrs_tgt_t tgt, next_tgt;
    logic issued, next_issued;
    logic req, next_req;
    logic abort, next_abort;
    logic [31:0] cnt, next_cnt;
    logic [7:0] next_cfg_data;
    logic next_self_cfg_wr;
    logic [IO_COUNT-1:0] next_io_cfg_wr;
    logic next_prog_wr;
    logic next_db_cfg_wr;
    logic next_fpga_stop;
    logic next_prog_run;
    logic next_eth_init_start;
    logic next_node_init_start;
    logic next_soft_rst;
    logic next_boot_done;
    logic next_boot_error;
    logic next_pll_rst;
    logic next_sys_clk_en;
    logic tgt_ok;
    logic timed_out;

    assign fl.req = req;
    assign fl.abort = abort;
    assign fl.addr = tgt_addr(tgt);
    assign fl.len = tgt_len(tgt);
    assign boot_busy = (state != ST_DONE) && (state != ST_ERROR);
    assign timed_out = (cnt == TIMEOUT_LAST);

    // Done condition of the target now being configured
    always_comb begin
        case (tgt)
            TGT_SELF: tgt_ok = self_cfg_done;
            TGT_IO0: tgt_ok = io_cfg_done[0];
            TGT_IO1: tgt_ok = io_cfg_done[1];
            TGT_PROG: tgt_ok = 1'b1;
            TGT_DB: tgt_ok = &db_cfg_done;
            default: tgt_ok = 1'b0;
        endcase
    end

    always_comb begin
        next_state = state;
        next_tgt = tgt;
        next_issued = issued;
        next_req = 1'b0;
        next_abort = 1'b0;
        next_cnt = cnt;
        next_cfg_data = cfg_data;
        next_self_cfg_wr = 1'b0;
        next_io_cfg_wr = '0;
        next_prog_wr = 1'b0;
        next_db_cfg_wr = 1'b0;
        next_fpga_stop = fpga_stop;
        next_prog_run = prog_run;
        next_eth_init_start = 1'b0;
        next_node_init_start = 1'b0;
        next_soft_rst = soft_rst;
        next_boot_done = boot_done;
        next_boot_error = boot_error;
        if (hard_reset_btn) begin
            // Everything downstream is held unconfigured until release
            next_state = ST_STOP;
            next_fpga_stop = 1'b1;
            next_abort = 1'b1;
            next_issued = 1'b0;
            next_cnt = 32'h0000_0000;
            next_prog_run = 1'b0;
            next_soft_rst = 1'b0;
            next_boot_done = 1'b0;
            next_boot_error = 1'b0;
        end else begin
            case (state)
                ST_STOP: begin
                    next_fpga_stop = 1'b0;
                    next_tgt = TGT_SELF;
                    next_issued = 1'b0;
                    next_state = ST_LOAD;
                end
                ST_LOAD: begin
                    if (!issued) begin
                        next_req = 1'b1;
                        next_issued = 1'b1;
                    end
                    if (fl.valid) begin
                        next_cfg_data = fl.data;
                        next_self_cfg_wr = (tgt == TGT_SELF);
                        next_io_cfg_wr[0] = (tgt == TGT_IO0);
                        next_io_cfg_wr[1] = (tgt == TGT_IO1);
                        next_prog_wr = (tgt == TGT_PROG);
                        // One strobe feeds every detector board at once
                        next_db_cfg_wr = (tgt == TGT_DB);
                    end
                    if (fl.done) begin
                        next_cnt = 32'h0000_0000;
                        next_state = ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    next_cnt = cnt + 32'h0000_0001;
                    next_issued = 1'b0;
                    if (tgt_ok) begin
                        next_cnt = 32'h0000_0000;
                        case (tgt)
                            TGT_SELF: begin
                                next_tgt = TGT_IO0;
                                next_state = ST_LOAD;
                            end
                            TGT_IO0: begin
                                next_tgt = TGT_IO1;
                                next_state = ST_LOAD;
                            end
                            TGT_IO1: begin
                                next_tgt = TGT_PROG;
                                next_state = ST_LOAD;
                            end
                            TGT_PROG: begin
                                next_prog_run = 1'b1;
                                next_eth_init_start = 1'b1;
                                next_state = ST_ETH;
                            end
                            default: begin
                                next_state = ST_SETTLE;
                            end
                        endcase
                    end else if (timed_out) begin
                        next_boot_error = 1'b1;
                        next_state = ST_ERROR;
                    end
                end
                ST_ETH: begin
                    next_cnt = cnt + 32'h0000_0001;
                    if (eth_init_done) begin
                        next_cnt = 32'h0000_0000;
                        next_node_init_start = 1'b1;
                        next_state = ST_NODE;
                    end else if (timed_out) begin
                        next_boot_error = 1'b1;
                        next_state = ST_ERROR;
                    end
                end
                ST_NODE: begin
                    next_cnt = cnt + 32'h0000_0001;
                    if (node_init_done) begin
                        next_cnt = 32'h0000_0000;
                        next_state = ST_SOFT;
                    end else if (timed_out) begin
                        next_boot_error = 1'b1;
                        next_state = ST_ERROR;
                    end
                end
                ST_SOFT: begin
                    // Soft reset counts only with the PLL locked
                    if (pll_locked && !pll_rst) begin
                        next_soft_rst = 1'b1;
                        next_cnt = cnt + 32'h0000_0001;
                        if (soft_rst && cnt == SOFT_LAST) begin
                            next_soft_rst = 1'b0;
                            next_cnt = 32'h0000_0000;
                            next_tgt = TGT_DB;
                            next_state = ST_LOAD;
                        end
                    end
                end
                ST_SETTLE: begin
                    next_cnt = cnt + 32'h0000_0001;
                    if ((&io_idle) && (&db_idle)) begin
                        next_boot_done = 1'b1;
                        next_state = ST_DONE;
                    end else if (timed_out) begin
                        next_boot_error = 1'b1;
                        next_state = ST_ERROR;
                    end
                end
                ST_DONE: begin
                    next_state = ST_DONE;
                end
                ST_ERROR: begin
                    // Stays here until a hard reset restarts the boot
                    next_state = ST_ERROR;
                end
                default: begin
                    next_state = ST_STOP;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state <= ST_STOP;
            tgt <= TGT_SELF;
            issued <= 1'b0;
            req <= 1'b0;
            abort <= 1'b0;
            cnt <= 32'h0000_0000;
            cfg_data <= 8'h00;
            self_cfg_wr <= 1'b0;
            io_cfg_wr <= '0;
            prog_wr <= 1'b0;
            db_cfg_wr <= 1'b0;
            fpga_stop <= 1'b1;
            prog_run <= 1'b0;
            eth_init_start <= 1'b0;
            node_init_start <= 1'b0;
            soft_rst <= 1'b0;
            boot_done <= 1'b0;
            boot_error <= 1'b0;
        end else begin
            state <= next_state;
            tgt <= next_tgt;
            issued <= next_issued;
            req <= next_req;
            abort <= next_abort;
            cnt <= next_cnt;
            cfg_data <= next_cfg_data;
            self_cfg_wr <= next_self_cfg_wr;
            io_cfg_wr <= next_io_cfg_wr;
            prog_wr <= next_prog_wr;
            db_cfg_wr <= next_db_cfg_wr;
            fpga_stop <= next_fpga_stop;
            prog_run <= next_prog_run;
            eth_init_start <= next_eth_init_start;
            node_init_start <= next_node_init_start;
            soft_rst <= next_soft_rst;
            boot_done <= next_boot_done;
            boot_error <= next_boot_error;
        end
    end

    // PLL control; configuration state is left untouched by a firmware reset
    always_comb begin
        next_pll_rst = hard_reset_btn | fw_reset_req;
        next_sys_clk_en = pll_locked & ~next_pll_rst;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pll_rst <= 1'b1;
            sys_clk_en <= 1'b0;
        end else begin
            pll_rst <= next_pll_rst;
            sys_clk_en <= next_sys_clk_en;
        end
    end

endmodule

// ### sbrs_boot_chk.sv
`timescale 1ns/1ps
module sbrs_boot_chk
    import sbrs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic hard_reset_btn,
    input wire logic fw_reset_req,
    input wire logic pll_locked,
    input wire logic flash_sck,
    input wire logic flash_cs_n,
    input wire logic self_cfg_wr,
    input wire logic [sbrs_pkg::IO_COUNT-1:0] io_cfg_wr,
    input wire logic prog_wr,
    input wire logic db_cfg_wr,
    input wire logic fpga_stop,
    input wire logic prog_run,
    input wire logic pll_rst,
    input wire logic sys_clk_en,
    input wire logic boot_busy,
    input wire logic boot_done
);
    import sbrs_pkg::*;
    logic any_wr;
    assign any_wr = self_cfg_wr | (|io_cfg_wr) | prog_wr | db_cfg_wr;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    chk_pll_follow: assert property (!$past(reset) |-> pll_rst == $past(hard_reset_btn | fw_reset_req))
        else $error("pll_rst does not track reset requests");
    chk_clk_gate: assert property (!$past(reset) |-> sys_clk_en == $past(pll_locked & ~(hard_reset_btn | fw_reset_req)))
        else $error("sys_clk_en does not track pll lock");
    chk_hard_stop: assert property (hard_reset_btn |=> fpga_stop && !prog_run && !boot_done)
        else $error("hard reset did not stop the system");
    chk_hard_flash: assert property (hard_reset_btn |-> ##3 flash_cs_n)
        else $error("flash still selected after hard reset");
    chk_one_target: assert property ($onehot0({self_cfg_wr, io_cfg_wr, prog_wr, db_cfg_wr}))
        else $error("two targets written at once");
    chk_byte_gap: assert property (any_wr |=> !any_wr [*8])
        else $error("config strobes too close");
    chk_sck_idle: assert property (flash_cs_n |-> !flash_sck)
        else $error("flash clock runs while deselected");
    chk_done_idle: assert property (boot_done |-> !boot_busy && !fpga_stop)
        else $error("boot done while busy or stopped");
    chk_stop_quiet: assert property (fpga_stop |-> !any_wr)
        else $error("config strobe while stopped");
    cover property (self_cfg_wr);
    cover property (hard_reset_btn ##1 fpga_stop);
    cover property (fw_reset_req ##1 pll_rst);
endmodule
bind sbrs_boot_sequencer sbrs_boot_chk i_chk (.clk_sys, .reset, .hard_reset_btn, .fw_reset_req,
    .pll_locked, .flash_sck, .flash_cs_n, .self_cfg_wr, .io_cfg_wr, .prog_wr, .db_cfg_wr,
    .fpga_stop, .prog_run, .pll_rst, .sys_clk_en, .boot_busy, .boot_done);

// ### sbrs_flash_model.sv
`timescale 1ns/1ps
module sbrs_flash_model (
    input wire logic flash_sck,
    input wire logic flash_cs_n,
    input wire logic flash_mosi,
    output logic flash_miso,
    output logic [31:0] hdr,
    output logic [31:0] nbits
);
    logic [31:0] a;
    logic [7:0] d;
    initial begin
        flash_miso = 1'h0;
        hdr = 32'h0;
        nbits = 32'h0;
    end
    // Released line never shows the last bit
    always @(posedge flash_cs_n) begin
        nbits <= 32'h0;
        flash_miso <= ~flash_miso;
    end
    always @(posedge flash_sck) begin
        if (!flash_cs_n) begin
            if (nbits < 32'h20) hdr <= {hdr[30:0], flash_mosi};
            nbits <= nbits + 32'h1;
        end
    end
    always @(negedge flash_sck) begin
        a = hdr[23:0] + ((nbits - 32'h20) >> 3);
        d = a[7:0] ^ a[15:8] ^ 8'h5A;
        if (!flash_cs_n) flash_miso <= (nbits < 32'h20) ? ~flash_miso : d[3'h7 - nbits[2:0]];
    end
endmodule

// ### tb_system_boot_and_reset_sequencer.sv
`timescale 1ns/1ps
module tb_system_boot_and_reset_sequencer;
    import sbrs_pkg::*;
    logic clk_sys = 1'h0;
    logic reset = 1'h1;
    logic hard_reset_btn = 1'h0;
    logic fw_reset_req = 1'h0;
    logic pll_locked = 1'h1;
    logic all_done = 1'h0;
    logic flash_sck, flash_cs_n, flash_mosi, flash_miso, self_cfg_wr, prog_wr, db_cfg_wr;
    logic fpga_stop, prog_run, eth_init_start, node_init_start, soft_rst, pll_rst;
    logic sys_clk_en, boot_busy, boot_done, boot_error;
    logic [7:0] cfg_data;
    logic [1:0] io_cfg_wr;
    logic [31:0] hdr, nbits;
    int err_count = 0;
    int num_checks = 0;
    int gap;
    int pos;
    always #4 clk_sys = ~clk_sys;
    sbrs_boot_sequencer #(.SOFT_RST_CYC_P(20), .TGT_TIMEOUT_CYC_P(200)) i_dut (.clk_sys, .reset,
        .hard_reset_btn, .fw_reset_req, .pll_locked, .flash_sck, .flash_cs_n, .flash_mosi,
        .flash_miso, .self_cfg_done(all_done), .io_cfg_done({2{all_done}}),
        .io_idle({2{all_done}}), .db_cfg_done({8{all_done}}), .db_idle({8{all_done}}),
        .eth_init_done(all_done), .node_init_done(all_done), .cfg_data, .self_cfg_wr,
        .io_cfg_wr, .prog_wr, .db_cfg_wr, .fpga_stop, .prog_run, .eth_init_start,
        .node_init_start, .soft_rst, .pll_rst, .sys_clk_en, .boot_busy, .boot_done, .boot_error);
    sbrs_flash_model i_flash (.flash_sck, .flash_cs_n, .flash_mosi, .flash_miso, .hdr, .nbits);
    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic next_wr(input int lim);
        gap = 0;
        do begin
            @(negedge clk_sys);
            gap++;
        end while ((self_cfg_wr | (|io_cfg_wr) | prog_wr | db_cfg_wr) !== 1'h1 && gap < lim);
    endtask
    task automatic t_reset;
        @(negedge clk_sys);
        cmp("stop_in_reset", 1'h1, fpga_stop);
        cmp("pll_in_reset", 2'h2, {pll_rst, sys_clk_en});
        cmp("busy_in_reset", 3'h4, {boot_busy, boot_done, boot_error});
        @(posedge clk_sys);
        reset <= 1'h0;
        repeat (2) @(negedge clk_sys);
        cmp("stop_after_release", 1'h0, fpga_stop);
    endtask
    task automatic t_load;
        for (gap = 0; gap < 20 && flash_cs_n !== 1'h0; gap++) @(negedge clk_sys);
        for (pos = 0; pos < 4; pos++) begin
            next_wr(pos == 0 ? 200 : 40);
            if (pos == 0) cmp("header", {FLASH_READ_CMD, SELF_IMAGE_START[23:0]}, hdr);
            else cmp("byte_gap", 32'h10, gap);
            cmp("self_strobe", 1'h1, self_cfg_wr);
            cmp("self_byte", pos[7:0] ^ 8'h5A, cfg_data);
        end
    endtask
    task automatic t_early_done;
        @(posedge clk_sys);
        all_done <= 1'h1;
        repeat (2) begin
            next_wr(40);
            cmp("still_self", 1'h1, self_cfg_wr);
            cmp("no_io_write", 2'h0, io_cfg_wr);
            cmp("no_program", 6'h0, {prog_wr, prog_run, eth_init_start, node_init_start,
                soft_rst, db_cfg_wr});
        end
        @(posedge clk_sys);
        all_done <= 1'h0;
    endtask
    task automatic t_pll;
        @(posedge clk_sys);
        fw_reset_req <= 1'h1;
        repeat (2) @(negedge clk_sys);
        cmp("fw_reset", 3'h4, {pll_rst, sys_clk_en, fpga_stop});
        @(posedge clk_sys);
        fw_reset_req <= 1'h0;
        pll_locked <= 1'h0;
        repeat (2) @(negedge clk_sys);
        cmp("unlock_clk", 2'h0, {pll_rst, sys_clk_en});
        @(posedge clk_sys);
        pll_locked <= 1'h1;
        next_wr(40);
        cmp("load_goes_on", 2'h3, {self_cfg_wr, sys_clk_en});
    endtask
    task automatic t_hard;
        @(posedge clk_sys);
        hard_reset_btn <= 1'h1;
        repeat (3) @(negedge clk_sys);
        cmp("hard_stop", 4'hD, {fpga_stop, flash_cs_n, sys_clk_en, pll_rst});
        @(posedge clk_sys);
        hard_reset_btn <= 1'h0;
        t_load;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (9) @(posedge clk_sys);
        t_reset;
        t_load;
        t_early_done;
        t_pll;
        t_hard;
        conclude;
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #40000;
        err_count++;
        conclude;
    end
endmodule
